// *** include/ifb_params.svh ***
// Purpose: Offsets, reset values, bit positions and vector numbers of the flag bank
// Assumes: Word-aligned registers on a 32-bit AHB-Lite bus
// Notes:   Definitions only
`ifndef IFB_PARAMS_SVH
`define IFB_PARAMS_SVH

// ****************************************************************
// Register byte offsets (address bits 3:0 are all decoded to select the word)
// ****************************************************************
`define IFB_OFS_ENABLE_TWO     4'h0
`define IFB_OFS_FLAGS_ONE      4'h4
`define IFB_OFS_FLAGS_TWO      4'h8
`define IFB_OFS_WAKEUP_FLAGS   4'hC
`define IFB_OFS_VECTOR_STATUS  4'h0
`define IFB_ADDR_MSB           5
`define IFB_DECODE_BITS        4

// ****************************************************************
// Reset values
// ****************************************************************
`define IFB_RST_ENABLE_TWO     8'h00
`define IFB_RST_FLAGS_ONE      8'h20
`define IFB_RST_FLAGS_TWO      8'h00
`define IFB_RST_WAKEUP_FLAGS   8'h00

// ****************************************************************
// Bit positions
// ****************************************************************
`define IFB_BIT_DT             7
`define IFB_BIT_AD             6
`define IFB_BIT_FH             3
`define IFB_BIT_FL             2
`define IFB_BIT_TC             1
`define IFB_BIT_TB             0
`define IFB_BIT_TA             7
`define IFB_BIT_S1             6
`define IFB_BIT_FIXED_ONE      5
`define IFB_BIT_EXT2           2
`define IFB_BIT_WAKE_ENABLE    5
// Writable bits of each flag register and of enable register two
`define IFB_MASK_FLAGS_ONE     8'hDF
`define IFB_MASK_FLAGS_TWO     8'hCF
`define IFB_MASK_FLAGS_ONE_SM  8'h9B
`define IFB_MASK_FLAGS_TWO_SM  8'hCD
`define IFB_MASK_ENABLE_SM     8'hFD
`define IFB_MASK_ALL           8'hFF

// ****************************************************************
// Vector numbers
// ****************************************************************
`define IFB_VEC_NONE           5'h00
`define IFB_VEC_EXT0           5'h04
`define IFB_VEC_WAKEUP         5'h09
`define IFB_VEC_SERIAL_ONE     5'h0A
`define IFB_VEC_TIMER_A        5'h0B
`define IFB_VEC_TIMER_B        5'h0C
`define IFB_VEC_TIMER_C        5'h0D
`define IFB_VEC_TIMER_FL       5'h0E
`define IFB_VEC_TIMER_FH       5'h0F
`define IFB_VEC_CONVERTER      5'h13
`define IFB_VEC_DIRECT         5'h14

// ****************************************************************
// AHB encodings
// ****************************************************************
`define IFB_HTRANS_NONSEQ_BIT  1
`define IFB_HSIZE_WORD         3'h2

`endif

// *** include/ifb_pkg.sv ***
// Purpose: Shared types of the interrupt flag bank
// Assumes: Nothing beyond the params header
// Notes:   Types only
package ifb_pkg;
   typedef logic [7:0] ifb_byte_type;
   typedef logic [4:0] ifb_vector_type;
endpackage

// *** logic/ifb_flag_bank.sv ***
// Purpose: Enable register two, request flag registers one and two, wakeup flags
// Assumes: Peripheral events are one-cycle pulses on hclk; pins are asynchronous
// Notes:   AHB-Lite slave, zero wait states, always OKAY
//
// Local design decisions: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`include "ifb_params.svh"
`default_nettype none

module ifb_flag_bank #(
   parameter bit LARGE_VARIANT = 1'b1
) (
   // Clock and reset
   input  wire logic                   hclk,
   input  wire logic                   hresetn,
   // AHB-Lite slave
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic                        hreadyout,
   output logic                        hresp,
   output logic [31:0]                 hrdata,
   // External pins, asynchronous
   input  wire logic [4:0]             ext_int_pin,
   input  wire logic [7:0]             wake_pin,
   // Pin function and edge selection from the port and edge registers
   input  wire logic [4:0]             ext_int_pin_mode,
   input  wire logic [4:0]             ext_int_rising,
   input  wire logic [7:0]             wake_pin_mode,
   // Enable register one, held elsewhere
   input  wire logic [7:0]             interrupt_enable_one,
   // Peripheral events, one-cycle pulses; timer F mode, converter start flag and direct transfer on are levels
   input  wire logic                   timer_a_wrap,
   input  wire logic                   serial_unit_one_done,
   input  wire logic                   timer_b_wrap,
   input  wire logic                   timer_c_wrap_up,
   input  wire logic                   timer_c_wrap_down,
   input  wire logic                   timer_f_16bit_mode,
   input  wire logic                   timer_f_high_match,
   input  wire logic                   timer_f_full_match,
   input  wire logic                   timer_f_low_match,
   input  wire logic                   converter_done,
   input  wire logic                   converter_start_flag,
   input  wire logic                   direct_transfer_on,
   input  wire logic                   direct_transfer_after_sleep,
   // Toward the CPU
   output logic                        int_pending,
   output ifb_pkg::ifb_vector_type     int_vector,
   output logic                        wakeup_request
);

   initial begin
      if (LARGE_VARIANT !== 1'b0 && LARGE_VARIANT !== 1'b1) begin
         $error("LARGE_VARIANT must be 0 or 1");
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   ifb_pkg::ifb_byte_type interrupt_enable_two;
   ifb_pkg::ifb_byte_type interrupt_request_flags_one;
   ifb_pkg::ifb_byte_type interrupt_request_flags_two;
   ifb_pkg::ifb_byte_type wakeup_request_flags;

   // Reduced variant lacks timer C, serial one and external input 2
   localparam ifb_pkg::ifb_byte_type FLAGS_ONE_MASK =
      LARGE_VARIANT ? `IFB_MASK_FLAGS_ONE : `IFB_MASK_FLAGS_ONE_SM;
   localparam ifb_pkg::ifb_byte_type FLAGS_TWO_MASK =
      LARGE_VARIANT ? `IFB_MASK_FLAGS_TWO : `IFB_MASK_FLAGS_TWO_SM;
   localparam ifb_pkg::ifb_byte_type ENABLE_MASK =
      LARGE_VARIANT ? `IFB_MASK_ALL : `IFB_MASK_ENABLE_SM;

   // ****************************************************************
   // Bus slave
   // ****************************************************************
   logic                                  dp_write;
   logic [`IFB_DECODE_BITS-1:0]           dp_addr;
   logic                                  ap_valid;
   logic [`IFB_DECODE_BITS-1:0]           ap_addr;

   assign ap_valid  = hsel && hready && htrans[`IFB_HTRANS_NONSEQ_BIT];
   assign ap_addr   = haddr[`IFB_DECODE_BITS-1:0];
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_write <= 1'b0;
         dp_addr  <= `IFB_OFS_ENABLE_TWO;
      end else if (hready) begin
         dp_write <= ap_valid && hwrite;
         dp_addr  <= ap_addr;
      end
   end

   function automatic logic wr_hit(input logic [`IFB_DECODE_BITS-1:0] ofs);
      wr_hit = dp_write && (dp_addr == ofs);
   endfunction

   // Clear mask of a flag register: bits written 0 while writable
   function automatic ifb_pkg::ifb_byte_type clear_of(input logic hit,
                                                    input ifb_pkg::ifb_byte_type mask);
      clear_of = hit ? (~hwdata[7:0] & mask) : 8'h00;
   endfunction

   // Reads are launched from the address phase so data stand in the data phase;
   // unmapped offsets read zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (ap_valid && !hwrite) begin
         unique case (ap_addr)
            `IFB_OFS_ENABLE_TWO:   hrdata <= {24'h00_0000, interrupt_enable_two};
            `IFB_OFS_FLAGS_ONE:    hrdata <= {24'h00_0000, interrupt_request_flags_one};
            `IFB_OFS_FLAGS_TWO:    hrdata <= {24'h00_0000, interrupt_request_flags_two};
            `IFB_OFS_WAKEUP_FLAGS: hrdata <= {24'h00_0000, wakeup_request_flags};
            default:               hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // ****************************************************************
   // Pin synchronisers and edge detection
   // ****************************************************************
   logic [4:0] ext_meta;
   logic [4:0] ext_sync;
   logic [4:0] ext_prev;
   logic [7:0] wake_meta;
   logic [7:0] wake_sync;
   logic [7:0] wake_prev;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ext_meta  <= 5'h1F;
         ext_sync  <= 5'h1F;
         ext_prev  <= 5'h1F;
         wake_meta <= 8'hFF;
         wake_sync <= 8'hFF;
         wake_prev <= 8'hFF;
      end else begin
         ext_meta  <= ext_int_pin;
         ext_sync  <= ext_meta;
         ext_prev  <= ext_sync;
         wake_meta <= wake_pin;
         wake_sync <= wake_meta;
         wake_prev <= wake_sync;
      end
   end

   logic [4:0] ext_edge;
   logic [7:0] wake_fall;

   // Rising or falling per edge select, only on pins in interrupt mode
   assign ext_edge  = ext_int_pin_mode &
                      ((ext_int_rising & ext_sync & ~ext_prev) |
                       (~ext_int_rising & ~ext_sync & ext_prev));
   assign wake_fall = wake_pin_mode & ~wake_sync & wake_prev;

   // ****************************************************************
   // Enable register two
   // ****************************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         interrupt_enable_two <= `IFB_RST_ENABLE_TWO;
      end else if (wr_hit(`IFB_OFS_ENABLE_TWO)) begin
         // Reserved bits are stored as written; software keeps them 0
         interrupt_enable_two <= hwdata[7:0] & ENABLE_MASK;
      end
   end

   // ****************************************************************
   // Request flags
   // ****************************************************************
   ifb_pkg::ifb_byte_type set_one;
   ifb_pkg::ifb_byte_type set_two;

   always_comb begin
      set_one = 8'h00;
      set_one[`IFB_BIT_TA] = timer_a_wrap;
      set_one[`IFB_BIT_S1] = serial_unit_one_done;
      set_one[4:3] = ext_edge[4:3];
      set_one[`IFB_BIT_EXT2] = ext_edge[2];
      set_one[1:0] = ext_edge[1:0];
      set_one = set_one & FLAGS_ONE_MASK;
      set_two = 8'h00;
      set_two[`IFB_BIT_DT] = direct_transfer_on && direct_transfer_after_sleep;
      set_two[`IFB_BIT_AD] = converter_done && !converter_start_flag;
      set_two[`IFB_BIT_FH] = timer_f_16bit_mode ? timer_f_full_match
                                                : timer_f_high_match;
      set_two[`IFB_BIT_FL] = !timer_f_16bit_mode && timer_f_low_match;
      set_two[`IFB_BIT_TC] = timer_c_wrap_up || timer_c_wrap_down;
      set_two[`IFB_BIT_TB] = timer_b_wrap;
      set_two = set_two & FLAGS_TWO_MASK;
   end

   // Set term is ORed after the clear so a coincident event survives
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         interrupt_request_flags_one <= `IFB_RST_FLAGS_ONE;
      end else begin
         interrupt_request_flags_one <= (interrupt_request_flags_one &
            ~clear_of(wr_hit(`IFB_OFS_FLAGS_ONE), FLAGS_ONE_MASK)) | set_one;
         interrupt_request_flags_one[`IFB_BIT_FIXED_ONE] <= 1'b1;
      end
   end

   // Reserved bits 5:4 are never set and read zero, whatever is written
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         interrupt_request_flags_two <= `IFB_RST_FLAGS_TWO;
      end else begin
         interrupt_request_flags_two <= (interrupt_request_flags_two &
            ~clear_of(wr_hit(`IFB_OFS_FLAGS_TWO), FLAGS_TWO_MASK)) | set_two;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wakeup_request_flags <= `IFB_RST_WAKEUP_FLAGS;
      end else begin
         wakeup_request_flags <= (wakeup_request_flags &
            ~clear_of(wr_hit(`IFB_OFS_WAKEUP_FLAGS), `IFB_MASK_ALL)) | wake_fall;
      end
   end

   // ****************************************************************
   // Request forwarding and priority
   // ****************************************************************
   ifb_pkg::ifb_byte_type live_one;
   ifb_pkg::ifb_byte_type live_two;

   // Bit 5 of enable one is the wakeup enable; flag bit 5 is the fixed one
   assign live_one = interrupt_request_flags_one & interrupt_enable_one & FLAGS_ONE_MASK;
   assign live_two = interrupt_request_flags_two & interrupt_enable_two & FLAGS_TWO_MASK;
   assign wakeup_request = interrupt_enable_one[`IFB_BIT_WAKE_ENABLE] &&
                           (|wakeup_request_flags);

   // Fixed order: external 0..4, wakeup, serial one, A, B, C, FL, FH, converter, direct
   function automatic ifb_pkg::ifb_vector_type pick(input ifb_pkg::ifb_byte_type one,
                                                   input ifb_pkg::ifb_byte_type two,
                                                   input logic wake);
      pick = `IFB_VEC_NONE;
      if (two[`IFB_BIT_DT])        pick = `IFB_VEC_DIRECT;
      if (two[`IFB_BIT_AD])        pick = `IFB_VEC_CONVERTER;
      if (two[`IFB_BIT_FH])        pick = `IFB_VEC_TIMER_FH;
      if (two[`IFB_BIT_FL])        pick = `IFB_VEC_TIMER_FL;
      if (two[`IFB_BIT_TC])        pick = `IFB_VEC_TIMER_C;
      if (two[`IFB_BIT_TB])        pick = `IFB_VEC_TIMER_B;
      if (one[`IFB_BIT_TA])        pick = `IFB_VEC_TIMER_A;
      if (one[`IFB_BIT_S1])        pick = `IFB_VEC_SERIAL_ONE;
      if (wake)                    pick = `IFB_VEC_WAKEUP;
      for (int i = 4; i >= 0; i--) begin
         if (i != `IFB_BIT_FIXED_ONE && one[i]) begin
            pick = 5'(`IFB_VEC_EXT0 + i);
         end
      end
   endfunction

   // Registered so the vector is glitch-free; pending sources are untouched
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         int_pending <= 1'b0;
         int_vector  <= `IFB_VEC_NONE;
      end else begin
         int_pending <= (|live_one) || (|live_two) || wakeup_request;
         int_vector  <= pick(live_one, live_two, wakeup_request);
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   sequence s_clear_two_dt;
      wr_hit(`IFB_OFS_FLAGS_TWO) && !hwdata[`IFB_BIT_DT] && !set_two[`IFB_BIT_DT];
   endsequence

   property p_enable_reset;
      @(posedge hclk) $rose(hresetn) |-> interrupt_enable_two == `IFB_RST_ENABLE_TWO;
   endproperty
   a_enable_reset: assert property (p_enable_reset) else $error("enable two not reset");

   property p_fixed_one;
      @(posedge hclk) disable iff (!hresetn) interrupt_request_flags_one[`IFB_BIT_FIXED_ONE];
   endproperty
   a_fixed_one: assert property (p_fixed_one) else $error("fixed bit not one");

   property p_set_wins;
      @(posedge hclk) disable iff (!hresetn)
         set_one[`IFB_BIT_TA] |=> interrupt_request_flags_one[`IFB_BIT_TA];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("timer A event lost");

   property p_write_one_keeps;
      @(posedge hclk) disable iff (!hresetn)
         wr_hit(`IFB_OFS_FLAGS_TWO) && hwdata[`IFB_BIT_TB] && !set_two[`IFB_BIT_TB]
         |=> interrupt_request_flags_two[`IFB_BIT_TB] == $past(interrupt_request_flags_two[`IFB_BIT_TB]);
   endproperty
   a_write_one_keeps: assert property (p_write_one_keeps) else $error("write 1 changed flag");

   property p_clear_dt;
      @(posedge hclk) disable iff (!hresetn)
         s_clear_two_dt |=> !interrupt_request_flags_two[`IFB_BIT_DT];
   endproperty
   a_clear_dt: assert property (p_clear_dt) else $error("write 0 did not clear");

   property p_converter_set;
      @(posedge hclk) disable iff (!hresetn)
         converter_done && !converter_start_flag ##1 1'b1 |-> interrupt_request_flags_two[`IFB_BIT_AD];
   endproperty
   a_converter_set: assert property (p_converter_set) else $error("converter flag missed");

   property p_fl_16bit;
      @(posedge hclk) disable iff (!hresetn)
         !interrupt_request_flags_two[`IFB_BIT_FL] && timer_f_16bit_mode
         |=> !interrupt_request_flags_two[`IFB_BIT_FL];
   endproperty
   a_fl_16bit: assert property (p_fl_16bit) else $error("low flag set in 16-bit mode");

   property p_gate_tb;
      @(posedge hclk) disable iff (!hresetn)
         !interrupt_enable_two[`IFB_BIT_TB] && live_two == 8'h00 && live_one == 8'h00 &&
         !wakeup_request |=> !int_pending;
   endproperty
   a_gate_tb: assert property (p_gate_tb) else $error("pending while nothing enabled");

   property p_wake_vector;
      @(posedge hclk) disable iff (!hresetn)
         wakeup_request && live_one == 8'h00 |=> int_vector == `IFB_VEC_WAKEUP;
   endproperty
   a_wake_vector: assert property (p_wake_vector) else $error("wakeup vector wrong");

   property p_wake_fall;
      @(posedge hclk) disable iff (!hresetn)
         wake_pin_mode[0] && wake_prev[0] && !wake_sync[0] |=> wakeup_request_flags[0];
   endproperty
   a_wake_fall: assert property (p_wake_fall) else $error("wakeup flag missed");

   property p_ext0_first;
      @(posedge hclk) disable iff (!hresetn) live_one[0] |=> int_vector == `IFB_VEC_EXT0;
   endproperty
   a_ext0_first: assert property (p_ext0_first) else $error("priority wrong");

endmodule

`default_nettype wire

// *** tb/ifb_periph_model.sv ***
// Purpose: Peripheral side of the flag bank: timers, converter, serial unit
// Assumes: The bench requests events one clock ahead
// Notes:   Each event pulse lasts as long as its request is held; the bench requests one cycle
`timescale 1ns/1ps
`default_nettype none
module ifb_periph_model (
   // Clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // Event requests and the pulses they make
   input  wire logic [9:0] fire,
   output logic      [9:0] pulse
);
   // A registered stage, so pulses change only at a rising edge, one clock after the request
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pulse <= 10'h000;
      end else begin
         pulse <= fire;
      end
   end
endmodule
`default_nettype wire

// *** tb/interrupt_flag_enable_bank_tb.sv ***
// Purpose: Self-checking bench of the flag bank
// Assumes: Zero-wait slave; events come through the peripheral model
// Notes:   Enables and timer modes are random from a fixed seed
`timescale 1ns/1ps
`include "ifb_params.svh"
`default_nettype none
module interrupt_flag_enable_bank_tb;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic        int_pending, wakeup_request, f16 = 1'b0, dto = 1'b0, s, p, csf = 1'b0;
   ifb_pkg::ifb_vector_type int_vector;
   logic [4:0]  ext_int_pin, ext_int_rising, emode = 5'h1F;
   logic [7:0]  wake_pin = 8'hFF, en1 = 8'h00, en2, q, base, wmode = 8'hFF;
   logic [9:0]  fire = 10'h000, ev;
   logic [12:0] t;
   logic [15:0] ens;
   logic [3:0]  a;
   int          i, mismatches = 0, n_tests = 0;

   always #25 hclk = ~hclk;

   ifb_periph_model model (.hclk(hclk), .hresetn(hresetn), .fire(fire), .pulse(ev));

   ifb_flag_bank dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(`IFB_HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_int_pin(ext_int_pin),
      .wake_pin(wake_pin), .ext_int_pin_mode(emode), .ext_int_rising(ext_int_rising),
      .wake_pin_mode(wmode), .interrupt_enable_one(en1), .timer_a_wrap(ev[0]),
      .serial_unit_one_done(ev[1]), .timer_b_wrap(ev[2]), .timer_c_wrap_up(ev[3]),
      .timer_c_wrap_down(ev[4]), .timer_f_16bit_mode(f16), .timer_f_high_match(ev[5]),
      .timer_f_full_match(ev[6]), .timer_f_low_match(ev[7]), .converter_done(ev[8]),
      .converter_start_flag(csf), .direct_transfer_on(dto),
      .direct_transfer_after_sleep(ev[9]), .int_pending(int_pending),
      .int_vector(int_vector), .wakeup_request(wakeup_request));

   // ************************************************
   // Checking and bus tasks
   // ************************************************
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", what, exp, got);
         mismatches++;
      end
   endtask

   // Entered just after a rising edge; read data taken at the closing edge
   task automatic xfer(input logic w, input logic [3:0] ad, input logic [7:0] d,
                       output logic [7:0] rd);
      int n;
      n = 0;
      hsel <= 1'b1;
      haddr <= {28'h0, ad};
      hwrite <= w;
      htrans <= 2'h2;
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 20);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 40);
      rd = hrdata[7:0];
      chk("bus status", 8'h00, {7'h0, hresp | (|hrdata[31:8])});
      if (n >= 40) begin mismatches++; test_done(); end
   endtask

   // Flag one cycle after the pulse, request one more
   task automatic fire_ev(input logic [9:0] m);
      fire <= m;
      @(posedge hclk);
      fire <= 10'h000;
      repeat (3) @(posedge hclk);
   endtask

   // Packs vector, enable index into {en1,en2}, then {second register, bit}
   function automatic logic [12:0] info(input int k);
      case (k)
         0: return {5'h0B, 4'hF, 4'h7};
         1: return {5'h0A, 4'hE, 4'h6};
         2: return {5'h0C, 4'h0, 4'h8};
         3, 4: return {5'h0D, 4'h1, 4'h9};
         5, 6: return {5'h0F, 4'h3, 4'hB};
         7: return {5'h0E, 4'h2, 4'hA};
         8: return {5'h13, 4'h6, 4'hE};
         default: return {5'h14, 4'h7, 4'hF};
      endcase
   endfunction

   // ************************************************
   // Scenarios
   // ************************************************
   initial begin
      void'($urandom(32'hE03D));
      ext_int_rising = 5'($urandom);
      ext_int_pin = ~ext_int_rising;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int j = 0; j < 4; j++) begin
         xfer(1'b0, 4'(j * 4), 8'h00, q);
         chk("reset value", (j == 1) ? 8'h20 : 8'h00, q);
      end
      for (int k = 0; k < 40; k++) begin
         i = $urandom_range(9);
         t = info(i);
         en2 = 8'($urandom) & 8'hCF;
         en1 <= 8'($urandom);
         f16 <= (i == 5) ? 1'b0 : 1'($urandom);
         dto <= 1'($urandom);
         csf <= 1'($urandom);
         xfer(1'b1, `IFB_OFS_ENABLE_TWO, en2, q);
         xfer(1'b0, `IFB_OFS_ENABLE_TWO, 8'h00, q);
         chk("enable two", en2, q);
         fire_ev(10'(1) << i);
         s = (i == 6) ? f16 : (i == 7) ? !f16 : (i == 9) ? dto : (i == 8) ? !csf : 1'b1;
         a = t[3] ? `IFB_OFS_FLAGS_TWO : `IFB_OFS_FLAGS_ONE;
         base = t[3] ? 8'h00 : 8'h20;
         ens = {en1, en2};
         p = s & ens[t[7:4]];
         xfer(1'b0, a, 8'h00, q);
         chk("flag set", base | (8'(s) << t[2:0]), q);
         chk("pending", {7'h0, p}, {7'h0, int_pending});
         chk("vector", p ? {3'h0, t[12:8]} : 8'h00, {3'h0, int_vector});
         xfer(1'b1, a, 8'hFF, q);
         xfer(1'b0, a, 8'h00, q);
         chk("flag kept", base | (8'(s) << t[2:0]), q);
         xfer(1'b1, a, 8'h00, q);
         xfer(1'b0, a, 8'h00, q);
         chk("flag clear", base, q);
      end
      en1 <= 8'h21;
      emode <= 5'($urandom);
      wmode <= 8'($urandom);
      xfer(1'b1, `IFB_OFS_ENABLE_TWO, 8'h00, q);
      for (int j = 0; j < 8; j++) begin
         wake_pin[j] <= 1'b0;
         if (j < 5) ext_int_pin[j] <= ext_int_rising[j];
         repeat (6) @(posedge hclk);
         xfer(1'b0, `IFB_OFS_WAKEUP_FLAGS, 8'h00, q);
         chk("wake flag", 8'(wmode[j]) << j, q);
         chk("wake vector", {2'h0, wmode[j], (j == 0 && emode[0]) ? 5'h04 :
             wmode[j] ? 5'h09 : 5'h00}, {2'h0, wakeup_request, int_vector});
         xfer(1'b0, `IFB_OFS_FLAGS_ONE, 8'h00, q);
         chk("ext flag", (j < 5 && emode[j]) ? (8'h20 | (8'(1) << j)) : 8'h20, q);
         xfer(1'b1, `IFB_OFS_WAKEUP_FLAGS, 8'h00, q);
         xfer(1'b1, `IFB_OFS_FLAGS_ONE, 8'h00, q);
         wake_pin[j] <= 1'b1;
         if (j < 5) ext_int_pin[j] <= ~ext_int_rising[j];
      end
      en1 <= 8'h00;
      csf <= 1'b0;
      xfer(1'b1, `IFB_OFS_ENABLE_TWO, 8'h41, q);
      fire_ev(10'h104);
      chk("vector both", 8'h0C, {3'h0, int_vector});
      xfer(1'b1, `IFB_OFS_FLAGS_TWO, 8'hFE, q);
      repeat (2) @(posedge hclk);
      chk("vector left", 8'h13, {3'h0, int_vector});
      fork
         xfer(1'b1, `IFB_OFS_FLAGS_TWO, 8'h00, q);
         fire_ev(10'h004);
      join
      xfer(1'b0, `IFB_OFS_FLAGS_TWO, 8'h00, q);
      chk("set wins", 8'h01, q);
      // Mid-run reset must bring enable two back from 8'h41
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      xfer(1'b0, `IFB_OFS_ENABLE_TWO, 8'h00, q);
      chk("enable after reset", 8'h00, q);
      test_done();
   end
endmodule
`default_nettype wire
